// *** verilog/dct_top.v ***
// Dual counter/timer control: an 8-bit short counter and a 16-bit long counter with
// transmit and demodulation modes, register port and port pin outputs.
// Assumes a single 100 MHz system clock, synchronous inputs and a master that never waits.
//
// The strobed register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "dct_map.vh"

module dct_top (
  input wire sys_clk,
  input wire srst,
  input wire stop_wake_recovery,
  input wire [7:0] addr,
  input wire [7:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  output reg [7:0] rd_data,
  input wire demod_in,
  output reg short_counter_pin,
  output reg short_pin_sel,
  output reg long_counter_pin,
  output reg long_pin_sel,
  output reg combined_pin,
  output reg combined_pin_sel,
  output wire short_capture_irq,
  output wire short_timeout_irq,
  output wire long_capture_irq,
  output wire long_timeout_irq
);

  // One-hot states of the alternating sequence.
  localparam [2:0] PP_IDLE = 3'b001;
  localparam [2:0] PP_SHORT = 3'b010;
  localparam [2:0] PP_LONG = 3'b100;

  wire rst_all;
  wire wr_short, wr_common, wr_long;
  wire demod;
  wire [1:0] logic_sel, sub_sel;
  wire s_tick, l_tick, e_rise, e_fall;
  wire rise_det, fall_det, edge_det;
  wire s_act, l_act, s_term, l_term;
  wire s_start, l_start;
  wire short_counter_output, long_counter_output;
  reg comb_out;
  reg [7:0] common_q;
  reg s_en_q, s_single_q, s_tmo_q, s_capm_q, s_tmom_q, s_pin_q;
  reg [1:0] s_clk_q;
  reg l_en_q, l_single_q, l_tmo_q, l_capm_q, l_tmom_q, l_pin_q;
  reg [1:0] l_clk_q;
  reg [7:0] s_reload_q, s_cnt_q, rising_capture_q, falling_capture_q;
  reg [15:0] l_reload_q, l_cnt_q, l_capture_q;
  reg s_out_q, l_out_q, s_arm_q, l_arm_q;
  reg [2:0] pp_state_q;
  reg [2:0] pp_state_d;

  assign rst_all = srst || stop_wake_recovery;
  assign wr_short = wr_en && (addr == `DCT_ADDR_SHORT_CTRL);
  assign wr_common = wr_en && (addr == `DCT_ADDR_COMMON_CTRL);
  assign wr_long = wr_en && (addr == `DCT_ADDR_LONG_CTRL);
  assign demod = common_q[`DCT_CC_MODE];
  assign logic_sel = common_q[`DCT_CC_LOGIC_HI:`DCT_CC_LOGIC_LO];
  assign sub_sel = common_q[`DCT_CC_SUB_HI:`DCT_CC_SUB_LO];

  // ------------------------------------------------------------
  // Prescalers and input edge detector
  // ------------------------------------------------------------
  dct_prescaler u_short_div (
    .sys_clk(sys_clk),
    .srst(rst_all),
    .run(s_en_q),
    .div_sel(s_clk_q),
    .tick(s_tick)
  );

  dct_prescaler u_long_div (
    .sys_clk(sys_clk),
    .srst(rst_all),
    .run(l_en_q),
    .div_sel(l_clk_q),
    .tick(l_tick)
  );

  dct_edge_filter u_edge (
    .sys_clk(sys_clk),
    .srst(rst_all),
    .sig_in(demod_in),
    .width_sel(sub_sel),
    .rise(e_rise),
    .fall(e_fall)
  );

  // Edge selection: 00 falling, 01 rising, 1x both.
  assign rise_det = demod && e_rise && (logic_sel != `DCT_EDGE_FALLING);
  assign fall_det = demod && e_fall && (logic_sel != `DCT_EDGE_RISING);
  assign edge_det = rise_det || fall_det;

  // ------------------------------------------------------------
  // Transmit sequencing
  // ------------------------------------------------------------
  // Terminal count is reached on a tick while the count stands at zero.
  assign s_act = s_en_q && ((sub_sel != `DCT_SUB_ALTERNATE) || (pp_state_q != PP_LONG));
  assign l_act = l_en_q && ((sub_sel != `DCT_SUB_ALTERNATE) || (pp_state_q != PP_SHORT));
  assign s_term = !demod && s_act && s_tick && (s_cnt_q == 8'h00);
  assign l_term = !demod && l_act && l_tick && (l_cnt_q == 16'h0000);
  assign s_start = wr_short && wr_data[`DCT_CT_ENABLE] && !s_en_q;
  assign l_start = wr_long && wr_data[`DCT_CT_ENABLE] && !l_en_q;

  // Alternating sequence: the short counter runs first, each end hands over to the other.
  always @* begin
    pp_state_d = pp_state_q;
    case (pp_state_q)
      PP_IDLE: begin
        if (s_en_q || l_en_q) begin
          pp_state_d = PP_SHORT;
        end
      end
      PP_SHORT: begin
        if (s_term) begin
          pp_state_d = PP_LONG;
        end
      end
      PP_LONG: begin
        if (l_term) begin
          pp_state_d = PP_SHORT;
        end
      end
      default: pp_state_d = PP_IDLE;
    endcase
    // Leaving the alternating setting ends the sequence at once.
    if (demod || (sub_sel != `DCT_SUB_ALTERNATE) || (!s_en_q && !l_en_q)) begin
      pp_state_d = PP_IDLE;
    end
  end

  always @(posedge sys_clk) begin
    if (rst_all) begin
      pp_state_q <= PP_IDLE;
    end else begin
      pp_state_q <= pp_state_d;
    end
  end

  // ------------------------------------------------------------
  // Common control register
  // ------------------------------------------------------------
  // In demodulation the two low bits are edge flags; a new edge wins over a clear.
  always @(posedge sys_clk) begin
    if (rst_all) begin
      common_q <= `DCT_RST_BYTE;
    end else begin
      if (wr_common) begin
        common_q[7:2] <= {wr_data[7], 1'b0, wr_data[5:2]};
      end
      if (!demod) begin
        if (wr_common) begin
          common_q[1:0] <= wr_data[1:0];
        end
      end else begin
        if (rise_det) begin
          common_q[`DCT_CC_INIT_SHORT] <= 1'b1;
        end else if (wr_common && wr_data[`DCT_CC_INIT_SHORT]) begin
          common_q[`DCT_CC_INIT_SHORT] <= 1'b0;
        end
        if (fall_det) begin
          common_q[`DCT_CC_INIT_LONG] <= 1'b1;
        end else if (wr_common && wr_data[`DCT_CC_INIT_LONG]) begin
          common_q[`DCT_CC_INIT_LONG] <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Counter control registers
  // ------------------------------------------------------------
  // Clock field and capture mask survive stop recovery and clear only on power-on reset.
  always @(posedge sys_clk) begin
    if (srst) begin
      s_clk_q <= 2'h0;
      s_capm_q <= 1'b0;
      l_clk_q <= 2'h0;
      l_capm_q <= 1'b0;
    end else begin
      if (wr_short) begin
        s_clk_q <= wr_data[`DCT_CT_CLK_HI:`DCT_CT_CLK_LO];
        s_capm_q <= wr_data[`DCT_CT_CAP_MASK];
      end
      if (wr_long) begin
        l_clk_q <= wr_data[`DCT_CT_CLK_HI:`DCT_CT_CLK_LO];
        l_capm_q <= wr_data[`DCT_CT_CAP_MASK];
      end
    end
  end

  // Enable, mode, masks, routing and timeout flags; single pass drops the enable at its end.
  always @(posedge sys_clk) begin
    if (rst_all) begin
      s_en_q <= 1'b0;
      s_single_q <= 1'b0;
      s_tmom_q <= 1'b0;
      s_pin_q <= 1'b0;
      s_tmo_q <= 1'b0;
      l_en_q <= 1'b0;
      l_single_q <= 1'b0;
      l_tmom_q <= 1'b0;
      l_pin_q <= 1'b0;
      l_tmo_q <= 1'b0;
    end else begin
      if (wr_short) begin
        s_en_q <= wr_data[`DCT_CT_ENABLE];
        s_single_q <= wr_data[`DCT_CT_SINGLE];
        s_tmom_q <= wr_data[`DCT_CT_TMO_MASK];
        s_pin_q <= wr_data[`DCT_CT_PIN];
      end else if (s_term && s_single_q) begin
        s_en_q <= 1'b0;
      end
      if (wr_long) begin
        l_en_q <= wr_data[`DCT_CT_ENABLE];
        l_single_q <= wr_data[`DCT_CT_SINGLE];
        l_tmom_q <= wr_data[`DCT_CT_TMO_MASK];
        l_pin_q <= wr_data[`DCT_CT_PIN];
      end else if (l_term && l_single_q) begin
        l_en_q <= 1'b0;
      end
      // Set wins over a write-1 clear in the same cycle; a write of 0 leaves the flag alone.
      if (s_term || (demod && s_arm_q && s_tick && !edge_det && (s_cnt_q == 8'h01))) begin
        s_tmo_q <= 1'b1;
      end else if (wr_short && wr_data[`DCT_CT_TIMEOUT]) begin
        s_tmo_q <= 1'b0;
      end
      if (l_term || (demod && l_arm_q && l_tick && !(edge_det && !l_single_q) && (l_cnt_q == 16'h0001))) begin
        l_tmo_q <= 1'b1;
      end else if (wr_long && wr_data[`DCT_CT_TIMEOUT]) begin
        l_tmo_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Reload data registers
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rst_all) begin
      s_reload_q <= `DCT_RST_BYTE;
      l_reload_q <= `DCT_RST_WORD;
    end else begin
      if (wr_en && (addr == `DCT_ADDR_SHORT_RELOAD)) begin
        s_reload_q <= wr_data;
      end
      if (wr_en && (addr == `DCT_ADDR_LONG_RELOAD_LO)) begin
        l_reload_q[7:0] <= wr_data;
      end
      if (wr_en && (addr == `DCT_ADDR_LONG_RELOAD_HI)) begin
        l_reload_q[15:8] <= wr_data;
      end
    end
  end

  // ------------------------------------------------------------
  // Short counter
  // ------------------------------------------------------------
  // Transmit: count down, toggle and reload at terminal count. Demodulation: the first
  // edge arms, later edges capture the complemented count and reload all ones.
  always @(posedge sys_clk) begin
    if (rst_all) begin
      s_cnt_q <= `DCT_RST_BYTE;
      s_out_q <= 1'b0;
      s_arm_q <= 1'b0;
      rising_capture_q <= `DCT_RST_BYTE;
      falling_capture_q <= `DCT_RST_BYTE;
    end else if (s_start) begin
      s_cnt_q <= demod ? `DCT_DEMOD_SHORT_LOAD : s_reload_q;
      s_out_q <= common_q[`DCT_CC_INIT_SHORT];
      s_arm_q <= 1'b0;
    end else if (!s_en_q) begin
      s_arm_q <= 1'b0;
    end else if (demod) begin
      if (edge_det) begin
        s_arm_q <= 1'b1;
        s_cnt_q <= `DCT_DEMOD_SHORT_LOAD;
        if (s_arm_q && rise_det) begin
          rising_capture_q <= ~s_cnt_q;
        end
        if (s_arm_q && fall_det) begin
          falling_capture_q <= ~s_cnt_q;
        end
      end else if (s_arm_q && s_tick) begin
        s_cnt_q <= s_cnt_q - 8'h01;
      end
    end else if (s_term) begin
      s_cnt_q <= s_reload_q;
      s_out_q <= ~s_out_q;
    end else if (s_act && s_tick) begin
      s_cnt_q <= s_cnt_q - 8'h01;
    end
  end

  // ------------------------------------------------------------
  // Long counter
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rst_all) begin
      l_cnt_q <= `DCT_RST_WORD;
      l_out_q <= 1'b0;
      l_arm_q <= 1'b0;
      l_capture_q <= `DCT_RST_WORD;
    end else if (l_start) begin
      l_cnt_q <= demod ? `DCT_DEMOD_LONG_LOAD : l_reload_q;
      l_out_q <= common_q[`DCT_CC_INIT_LONG];
      l_arm_q <= 1'b0;
    end else if (!l_en_q) begin
      l_arm_q <= 1'b0;
    end else if (demod) begin
      if (edge_det && !l_single_q) begin
        l_arm_q <= 1'b1;
        l_cnt_q <= `DCT_DEMOD_LONG_LOAD;
        if (l_arm_q) begin
          l_capture_q <= ~l_cnt_q;
        end
      end else if (l_arm_q && l_tick) begin
        l_cnt_q <= l_cnt_q - 16'h0001;
      end
    end else if (l_term) begin
      l_cnt_q <= l_reload_q;
      l_out_q <= ~l_out_q;
    end else if (l_act && l_tick) begin
      l_cnt_q <= l_cnt_q - 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // Outputs and pin routing
  // ------------------------------------------------------------
  // Unless the long level is forced, a stopped counter shows the opposite of its initial level so starting gives an edge.
  assign short_counter_output = s_en_q ? s_out_q : ~common_q[`DCT_CC_INIT_SHORT];
  assign long_counter_output = (!demod && sub_sel[1]) ? sub_sel[0] :
                               (l_en_q ? l_out_q : ~common_q[`DCT_CC_INIT_LONG]);

  // Combining function of the two outputs.
  always @* begin
    case (logic_sel)
      `DCT_LOGIC_AND: comb_out = short_counter_output & long_counter_output;
      `DCT_LOGIC_OR: comb_out = short_counter_output | long_counter_output;
      `DCT_LOGIC_NOR: comb_out = ~(short_counter_output | long_counter_output);
      default: comb_out = ~(short_counter_output & long_counter_output);
    endcase
  end

  // Pins are registered, so a forced level shows one cycle after the write.
  always @(posedge sys_clk) begin
    if (rst_all) begin
      short_counter_pin <= 1'b0;
      short_pin_sel <= 1'b0;
      long_counter_pin <= 1'b0;
      long_pin_sel <= 1'b0;
      combined_pin <= 1'b0;
      combined_pin_sel <= 1'b0;
    end else begin
      short_counter_pin <= short_counter_output;
      short_pin_sel <= s_pin_q;
      long_counter_pin <= long_counter_output;
      long_pin_sel <= l_pin_q;
      combined_pin <= comb_out;
      combined_pin_sel <= !demod && s_pin_q && l_pin_q &&
                          (common_q[`DCT_CC_LOGIC_HI:`DCT_CC_LOGIC_LO] == logic_sel);
    end
  end

  // Interrupt requests are level outputs gated by their enables.
  assign short_capture_irq = s_capm_q && demod && (common_q[1] || common_q[0]);
  assign short_timeout_irq = s_tmom_q && s_tmo_q;
  assign long_capture_irq = l_capm_q && demod && (common_q[1] || common_q[0]);
  assign long_timeout_irq = l_tmom_q && l_tmo_q;

  // ------------------------------------------------------------
  // Register read port
  // ------------------------------------------------------------
  // Read data stand only in the cycle after the strobe; unmapped offsets read zero.
  always @(posedge sys_clk) begin
    if (srst) begin
      rd_data <= `DCT_RST_BYTE;
    end else if (!rd_en) begin
      rd_data <= `DCT_RST_BYTE;
    end else begin
      case (addr)
        `DCT_ADDR_SHORT_CTRL: rd_data <= {s_en_q, s_single_q, s_tmo_q, s_clk_q, s_capm_q, s_tmom_q, s_pin_q};
        `DCT_ADDR_COMMON_CTRL: rd_data <= common_q;
        `DCT_ADDR_LONG_CTRL: rd_data <= {l_en_q, l_single_q, l_tmo_q, l_clk_q, l_capm_q, l_tmom_q, l_pin_q};
        `DCT_ADDR_SHORT_RELOAD: rd_data <= s_reload_q;
        `DCT_ADDR_LONG_RELOAD_LO: rd_data <= l_reload_q[7:0];
        `DCT_ADDR_LONG_RELOAD_HI: rd_data <= l_reload_q[15:8];
        `DCT_ADDR_RISING_CAPTURE: rd_data <= rising_capture_q;
        `DCT_ADDR_FALLING_CAPTURE: rd_data <= falling_capture_q;
        `DCT_ADDR_LONG_CAPTURE_LO: rd_data <= l_capture_q[7:0];
        `DCT_ADDR_LONG_CAPTURE_HI: rd_data <= l_capture_q[15:8];
        default: rd_data <= `DCT_RST_BYTE;
      endcase
    end
  end

endmodule // dct_top
`default_nettype wire

// *** verilog/dct_map.vh ***
// Register offsets, field positions, reset values and timing counts of the dual counter/timer control.
// Assumes inclusion by bare name from each design file; definitions only.
`ifndef DCT_MAP_VH
`define DCT_MAP_VH

// Register offsets on the plain register port (8-bit address).
`define DCT_ADDR_SHORT_CTRL 8'h00
`define DCT_ADDR_COMMON_CTRL 8'h01
`define DCT_ADDR_LONG_CTRL 8'h02
`define DCT_ADDR_SHORT_RELOAD 8'h03
`define DCT_ADDR_LONG_RELOAD_LO 8'h04
`define DCT_ADDR_LONG_RELOAD_HI 8'h05
`define DCT_ADDR_RISING_CAPTURE 8'h06
`define DCT_ADDR_FALLING_CAPTURE 8'h07
`define DCT_ADDR_LONG_CAPTURE_LO 8'h08
`define DCT_ADDR_LONG_CAPTURE_HI 8'h09

// Common control fields.
`define DCT_CC_MODE 7
`define DCT_CC_LOGIC_HI 5
`define DCT_CC_LOGIC_LO 4
`define DCT_CC_SUB_HI 3
`define DCT_CC_SUB_LO 2
`define DCT_CC_INIT_SHORT 1
`define DCT_CC_INIT_LONG 0

// Counter control fields, same layout for both counters.
`define DCT_CT_ENABLE 7
`define DCT_CT_SINGLE 6
`define DCT_CT_TIMEOUT 5
`define DCT_CT_CLK_HI 4
`define DCT_CT_CLK_LO 3
`define DCT_CT_CAP_MASK 2
`define DCT_CT_TMO_MASK 1
`define DCT_CT_PIN 0

// Field codes.
`define DCT_LOGIC_AND 2'h0
`define DCT_LOGIC_OR 2'h1
`define DCT_LOGIC_NOR 2'h2
`define DCT_LOGIC_NAND 2'h3
`define DCT_SUB_NORMAL 2'h0
`define DCT_SUB_ALTERNATE 2'h1
`define DCT_EDGE_FALLING 2'h0
`define DCT_EDGE_RISING 2'h1

// Reset values and demodulation load values.
`define DCT_RST_BYTE 8'h00
`define DCT_RST_WORD 16'h0000
`define DCT_DEMOD_SHORT_LOAD 8'hFF
`define DCT_DEMOD_LONG_LOAD 16'hFFFF

// Glitch filter: a new input level must stand this many system clocks per code.
`define DCT_GLITCH_CNT_W 4
`define DCT_GLITCH_0 4'h1
`define DCT_GLITCH_1 4'h2
`define DCT_GLITCH_2 4'h4
`define DCT_GLITCH_3 4'h8

`endif

// *** verilog/dct_prescaler.v ***
// Counter clock prescaler: a one-cycle enable at the system clock divided by 1, 2, 4 or 8.
// Assumes a single system clock domain and synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
`include "dct_map.vh"

module dct_prescaler (
  input wire sys_clk,
  input wire srst,
  input wire run,
  input wire [1:0] div_sel,
  output wire tick
);

  reg [2:0] div_q;
  reg [2:0] mask;

  // ------------------------------------------------------------
  // Divider
  // ------------------------------------------------------------
  // Mask of the low divider bits that must all be set for a tick.
  always @* begin
    case (div_sel)
      2'h0: mask = 3'h0;
      2'h1: mask = 3'h1;
      2'h2: mask = 3'h3;
      default: mask = 3'h7;
    endcase
  end

  // The divider restarts while stopped so the first interval is full.
  always @(posedge sys_clk) begin
    if (srst || !run) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end

  assign tick = run && ((div_q & mask) == mask);

endmodule // dct_prescaler
`default_nettype wire

// *** verilog/dct_edge_filter.v ***
// Glitch filter and edge detector on the demodulation input.
// Assumes the input is already synchronous to sys_clk.
`timescale 1ns/100ps
`default_nettype none
`include "dct_map.vh"

module dct_edge_filter (
  input wire sys_clk,
  input wire srst,
  input wire sig_in,
  input wire [1:0] width_sel,
  output wire rise,
  output wire fall
);

  reg level_q;
  reg [`DCT_GLITCH_CNT_W-1:0] cnt_q;
  reg [`DCT_GLITCH_CNT_W-1:0] need;
  wire accept;

  // ------------------------------------------------------------
  // Filter
  // ------------------------------------------------------------
  // Required stable length for the selected glitch width.
  always @* begin
    case (width_sel)
      2'h0: need = `DCT_GLITCH_0;
      2'h1: need = `DCT_GLITCH_1;
      2'h2: need = `DCT_GLITCH_2;
      default: need = `DCT_GLITCH_3;
    endcase
  end

  // A pulse shorter than the window is dropped, since the count restarts on each bounce.
  assign accept = (sig_in != level_q) && ((cnt_q + 4'h1) >= need);

  always @(posedge sys_clk) begin
    if (srst) begin
      level_q <= 1'b0;
      cnt_q <= 4'h0;
    end else if (sig_in == level_q) begin
      cnt_q <= 4'h0;
    end else if (accept) begin
      level_q <= sig_in;
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  assign rise = accept && sig_in;
  assign fall = accept && !sig_in;

endmodule // dct_edge_filter
`default_nettype wire

// *** verif/dct_chk.sv ***
// Port checker of the dual counter/timer control.
// Assumes it sees only dct_top ports and that control bytes change by software writes.
`timescale 1ns/100ps
`default_nettype none
`include "dct_map.vh"
module dct_chk (
  input wire sys_clk,
  input wire srst,
  input wire stop_wake_recovery,
  input wire [7:0] addr,
  input wire [7:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] rd_data,
  input wire short_counter_pin,
  input wire short_pin_sel,
  input wire long_counter_pin,
  input wire long_pin_sel,
  input wire combined_pin_sel,
  input wire long_capture_irq,
  input wire long_timeout_irq
);
  logic [7:0] sc_q, cc_q, lc_q;
  logic [2:0] quiet_q;
  wire wr_s = wr_en && addr == `DCT_ADDR_SHORT_CTRL;
  wire wr_c = wr_en && addr == `DCT_ADDR_COMMON_CTRL;
  wire wr_l = wr_en && addr == `DCT_ADDR_LONG_CTRL;
  wire settled_tx = quiet_q == 3'h7 && !cc_q[7] && cc_q[3:2] == 2'h0;
  // Shadows of written control bytes; recovery keeps only clock fields and capture mask.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sc_q <= 8'h00;
      cc_q <= 8'h00;
      lc_q <= 8'h00;
    end else if (stop_wake_recovery) begin
      sc_q <= sc_q & 8'h1C;
      cc_q <= 8'h00;
      lc_q <= lc_q & 8'h1C;
    end else begin
      sc_q <= wr_s ? wr_data : sc_q;
      cc_q <= wr_c ? wr_data : cc_q;
      lc_q <= wr_l ? wr_data : lc_q;
    end
  end
  // Cycles since a control write; settled checks wait so that registered pins have caught up.
  always_ff @(posedge sys_clk) begin
    if (srst || stop_wake_recovery || wr_s || wr_c || wr_l) begin
      quiet_q <= 3'h0;
    end else if (quiet_q != 3'h7) begin
      quiet_q <= quiet_q + 3'h1;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst || stop_wake_recovery);
  sequence s_run_long;
    wr_l && wr_data[7] && !wr_data[6];
  endsequence
  sequence s_force;
    wr_c && !wr_data[7] && wr_data[3];
  endsequence
  a_enable_readback: assert property (s_run_long ##2 rd_en && addr == `DCT_ADDR_LONG_CTRL |=> rd_data[7])
    else $error("enable bit not read back");
  a_read_quiet: assert property (!$past(rd_en) |-> rd_data == 8'h00)
    else $error("read data outside its cycle");
  a_force_level: assert property (s_force ##1 !wr_c |=> long_counter_pin == $past(wr_data[2], 2))
    else $error("forced long level wrong");
  a_long_idle: assert property (settled_tx && !lc_q[7] |-> long_counter_pin == !cc_q[0])
    else $error("stopped long level wrong");
  a_short_idle: assert property (settled_tx && !sc_q[7] |-> short_counter_pin == !cc_q[1])
    else $error("stopped short level wrong");
  a_long_start: assert property (settled_tx && wr_l && wr_data[7] && !lc_q[7] |->
    ##2 long_counter_pin == cc_q[0])
    else $error("long start level wrong");
  a_short_start: assert property (settled_tx && wr_s && wr_data[7] && !sc_q[7] |->
    ##2 short_counter_pin == cc_q[1])
    else $error("short start level wrong");
  a_irq_masked: assert property (quiet_q > 3'h1 |->
    (lc_q[1] || !long_timeout_irq) && (lc_q[2] || !long_capture_irq))
    else $error("masked request seen");
  a_pin_route: assert property (quiet_q > 3'h1 |-> long_pin_sel == lc_q[0] && short_pin_sel == sc_q[0]
    && combined_pin_sel == (!cc_q[7] && sc_q[0] && lc_q[0]))
    else $error("pin routing wrong");
endmodule // dct_chk
bind dct_top dct_chk i_dct_chk (
  .sys_clk(sys_clk), .srst(srst), .stop_wake_recovery(stop_wake_recovery), .addr(addr), .wr_data(wr_data),
  .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .short_counter_pin(short_counter_pin),
  .short_pin_sel(short_pin_sel), .long_counter_pin(long_counter_pin), .long_pin_sel(long_pin_sel),
  .combined_pin_sel(combined_pin_sel), .long_capture_irq(long_capture_irq), .long_timeout_irq(long_timeout_irq)
);
`default_nettype wire

// *** verif/dct_sig_src.sv ***
// Source of the modulated input signal seen by the demodulator.
// Assumes callers step it just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module dct_sig_src (
  input wire sys_clk,
  output var logic demod_in
);
  initial demod_in = 1'b0;
  // Holds a level for some clocks; a short hold makes a glitch the filter must reject.
  task automatic hold(input logic lvl, input int n);
    demod_in <= lvl;
    repeat (n) @(posedge sys_clk);
  endtask
endmodule // dct_sig_src
`default_nettype wire

// *** verif/dct_tb_top.sv ***
// Self-checking bench of dct_top driven through its register port.
// Assumes the design, checker and signal source are compiled first.
`timescale 1ns/100ps
`default_nettype none
module dct_tb_top;
  logic sys_clk, srst, swr, wr_en, rd_en, sp, lp, cp, spl, lpl, cpl, sci, sti, lci, lti;
  logic [7:0] addr, wr_data, rd_data;
  logic [2:0] e;
  int miscompares, total_checks, n, x;
  wire demod_in;
  dct_sig_src i_dct_sig_src (.sys_clk(sys_clk), .demod_in(demod_in));
  dct_top i_dct_top (.sys_clk(sys_clk), .srst(srst), .stop_wake_recovery(swr), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .demod_in(demod_in), .short_counter_pin(sp),
    .short_pin_sel(spl), .long_counter_pin(lp), .long_pin_sel(lpl), .combined_pin(cp), .combined_pin_sel(cpl),
    .short_capture_irq(sci), .short_timeout_irq(sti), .long_capture_irq(lci), .long_timeout_irq(lti));
  // Free-running system clock.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  // A gap cycle after each strobe keeps one assignment per signal per time step.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hFF);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 chk(rd_data & m, exp);
    @(posedge sys_clk);
  endtask
  task automatic pins(input logic [2:0] t);
    #1 chk({5'h00, sp, lp, cp}, {5'h00, t});
  endtask
  // Skips the first change, then times two half periods of the long pin and keeps the last.
  task automatic half(output int k);
    logic s;
    #1;
    repeat (3) begin
      s = lp;
      k = 0;
      while (lp === s && k < 300) begin
        @(posedge sys_clk);
        #1 k++;
      end
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Cuts a hang short well after the tests should have ended.
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    report_and_stop();
  end
  // Main test sequence.
  initial begin
    srst = 1'b1;
    swr = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wr_data = 8'h00;
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    rd(8'h02, 8'h00);
    rd(8'h01, 8'h00);
    rd(8'h0A, 8'h00);
    $display("test reset done");
    for (x = 0; x < 16; x++) begin
      wr(8'h01, {2'h0, x[3:2], 2'h0, x[1:0]});
      repeat (3) @(posedge sys_clk);
      e = {~x[1], ~x[0], 1'b0};
      e[0] = x[3] ^ ((x[2] ^ x[3]) ? e[2] | e[1] : e[2] & e[1]);
      pins(e);
      rd(8'h01, {2'h0, x[3:2], 2'h0, x[1:0]});
    end
    $display("test combine done");
    wr(8'h01, 8'h08);
    pins({~1'b0, 1'b0, 1'b0});
    wr(8'h01, 8'h0D);
    pins(3'b111);
    wr(8'h01, 8'h01);
    $display("test force done");
    wr(8'h04, 8'h03);
    repeat (8) @(posedge sys_clk);
    wr(8'h00, 8'h80);
    repeat (8) @(posedge sys_clk);
    wr(8'h02, 8'h80);
    half(n);
    chk(n[7:0], 8'h04);
    rd(8'h02, 8'hA0);
    wr(8'h02, 8'h00);
    rd(8'h02, 8'h20);
    wr(8'h02, 8'h20);
    rd(8'h02, 8'h00);
    wr(8'h02, 8'hC0);
    repeat (20) @(posedge sys_clk);
    rd(8'h02, 8'h60);
    wr(8'h02, 8'h02);
    #1 chk({7'h00, lti}, 8'h01);
    wr(8'h02, 8'h98);
    rd(8'h02, 8'hB8);
    #1 chk({7'h00, lti}, 8'h00);
    half(n);
    chk(n[7:0], 8'h20);
    wr(8'h02, 8'h00);
    wr(8'h02, 8'h20);
    $display("test count done");
    wr(8'h00, 8'h00);
    wr(8'h02, 8'h1D);
    pins(3'b100);
    chk({7'h00, lpl}, 8'h01);
    swr <= 1'b1;
    @(posedge sys_clk);
    swr <= 1'b0;
    @(posedge sys_clk);
    rd(8'h02, 8'h1C);
    $display("test recovery done");
    wr(8'h01, 8'hA0);
    wr(8'h00, 8'h86);
    wr(8'h02, 8'hDC);
    i_dct_sig_src.hold(1'b1, 20);
    i_dct_sig_src.hold(1'b0, 20);
    rd(8'h07, 8'h10, 8'hF8);
    rd(8'h01, 8'hA3);
    chk({5'h00, sci, sti, lci}, 8'h05);
    rd(8'h08, 8'h00);
    wr(8'h01, 8'hA3);
    rd(8'h01, 8'hA0);
    wr(8'h01, 8'hAC);
    i_dct_sig_src.hold(1'b1, 3);
    i_dct_sig_src.hold(1'b0, 20);
    rd(8'h01, 8'hAC);
    wr(8'h01, 8'hA0);
    i_dct_sig_src.hold(1'b1, 3);
    i_dct_sig_src.hold(1'b0, 20);
    rd(8'h01, 8'hA3);
    $display("test demodulation done");
    report_and_stop();
  end
endmodule // dct_tb_top
`default_nettype wire
